//--- src/lcs_sequencer.sv
// four-channel led curing control: triggers, grouping, fan threshold and program sequencer
//
// Function
// - trigger input mode selects standard or pulse behaviour for foot switch and controller input.
// - standard mode foot switch: time 0 holds while pressed; else press starts timed shot.
// - standard mode controller input: on while high, limited by set time when nonzero.
// - power or radiation time written to one channel copies to its whole group.
// - grouping: four separate (default), pairs 1+2 and 3+4, or all four together.
// - fan switches on while led temperature is above the threshold.
// - fan threshold is writable and resets to 35 degrees Celsius.
// - units without a fan never get the fan output.
// - program store holds 99 lines, one instruction each.
// - each line waits its own programmed time before its instruction executes.
// - start begins at line 1, then advances one line per completed instruction.
// - a stop request halts the program at any moment.
// - jump instructions move execution to another line so sections repeat.
// - a whole downloaded program is accepted line by line into the store.
// - the sequencer halts after executing line 99 unless that line holds a valid jump.
// - an instruction that cannot run is skipped and the next line follows.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "lcs_defines.svh"
module lcs_sequencer #(
  parameter int TICK_CYCLES = `LCS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // triggers
  input  wire logic                 foot_switch,
  input  wire logic                 plc_in,
  // led units
  input  wire logic [3:0]           led_present,
  input  wire logic [3:0]           has_fan,
  input  wire logic [31:0]          led_temp,
  output logic      [3:0]           led_on,
  output logic      [31:0]          led_power,
  output logic      [3:0]           fan_on,
  output logic                      seq_running
);
  import lcs_pkg::*;

  logic        rst_q1;
  logic        rst_n;
  logic [31:0] tick_cnt;
  logic        tick;
  lcs_trig_t   trigger_input_mode;
  lcs_grp_t    channel_grouping;
  logic [7:0]  fan_on_threshold;
  logic [15:0] rad_time [4];
  logic [6:0]  prog_addr;
  logic [27:0] prog [`LCS_LINES];
  logic        foot_d;
  logic        plc_d;
  lcs_seq_t    state;
  logic [6:0]  line;
  logic [15:0] wait_cnt;
  logic [3:0]  seq_led;
  logic [27:0] cur;
  lcs_op_t     cur_op;
  logic [7:0]  cur_arg;
  logic        wr_start;
  logic        wr_stop;
  logic        last_line;

  // true when channel b shares the group of channel a
  function automatic logic in_group(lcs_grp_t g, logic [1:0] a, logic [1:0] b);
    case (g)
      LCS_GRP_PAIRS: in_group = (a[1] == b[1]);
      LCS_GRP_ALL:   in_group = 1'b1;
      default:       in_group = (a == b);
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // 100 ms time base shared by radiation and wait timers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end
    else if (tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  assign wr_start = reg_wr && reg_addr == `LCS_ADDR_CTRL && reg_wdata[`LCS_CTRL_START];
  assign wr_stop  = reg_wr && reg_addr == `LCS_ADDR_CTRL && reg_wdata[`LCS_CTRL_STOP];

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigger_input_mode <= LCS_TRIG_STANDARD;
      channel_grouping   <= LCS_GRP_SEPARATE;
      fan_on_threshold   <= `LCS_FAN_RST;
      prog_addr          <= 7'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `LCS_ADDR_CTRL:
        begin
          trigger_input_mode <= lcs_trig_t'(reg_wdata[`LCS_CTRL_MODE]);
          // unused grouping code 3 falls back to separate channels
          channel_grouping   <= (reg_wdata[`LCS_CTRL_GRP_HI:`LCS_CTRL_GRP_LO] == 2'h3) ? LCS_GRP_SEPARATE :
                                lcs_grp_t'(reg_wdata[`LCS_CTRL_GRP_HI:`LCS_CTRL_GRP_LO]);
        end
        `LCS_ADDR_FAN:   fan_on_threshold <= reg_wdata[7:0];
        `LCS_ADDR_PADDR: prog_addr <= reg_wdata[6:0];
        // auto-increment so a downloaded program streams in one word per line
        `LCS_ADDR_PDATA: prog_addr <= (prog_addr == `LCS_LAST_LINE) ? 7'h0 : prog_addr + 7'h1;
        default: ;
      endcase
    end
  end

  // program store, no reset: contents are defined only once loaded
  always_ff @(posedge ref_clk)
  begin
    if (reg_wr && reg_addr == `LCS_ADDR_PDATA && prog_addr <= `LCS_LAST_LINE)
      prog[prog_addr] <= reg_wdata[27:0];
  end

  // trigger input history for edge detection
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      foot_d <= 1'b0;
      plc_d  <= 1'b0;
    end
    else
    begin
      foot_d <= foot_switch;
      plc_d  <= plc_in;
    end
  end

  // per-channel settings, triggers and fan
  for (genvar c = 0; c < 4; c++)
  begin : g_ch
    logic        run;
    logic        from_plc;
    logic [15:0] rt_cnt;
    logic        time0;
    logic        foot_edge;
    logic        plc_edge;
    logic        expired;
    logic        level_on;

    assign time0     = (rad_time[c] == 16'h0);
    assign foot_edge = foot_switch && !foot_d;
    assign plc_edge  = plc_in && !plc_d;
    assign expired   = !time0 && rt_cnt >= rad_time[c];
    // time 0 in standard mode follows the inputs directly
    assign level_on  = trigger_input_mode == LCS_TRIG_STANDARD && time0 && (foot_switch || plc_in);

    // grouped writes: every channel in the writer's group takes the value
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        led_power[8*c +: 8] <= `LCS_POWER_RST;
        rad_time[c]         <= 16'h0;
      end
      else if (reg_wr && in_group(channel_grouping, reg_addr[3:2], 2'(c)))
      begin
        if (reg_addr[7:4] == `LCS_BASE_POWER)
          led_power[8*c +: 8] <= reg_wdata[7:0];
        else if (reg_addr[7:4] == `LCS_BASE_TIME)
          rad_time[c] <= reg_wdata[15:0];
      end
    end

    // timed shot: standard mode one shot per press, pulse mode toggles on each edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        run      <= 1'b0;
        from_plc <= 1'b0;
        rt_cnt   <= 16'h0;
      end
      else if (trigger_input_mode == LCS_TRIG_PULSE && run && (foot_edge || plc_edge || expired))
        run <= 1'b0;
      else if (run && (expired || (from_plc && !plc_in && trigger_input_mode == LCS_TRIG_STANDARD)))
        run <= 1'b0;
      else if (!run && (foot_edge || plc_edge) && (!time0 || trigger_input_mode == LCS_TRIG_PULSE))
      begin
        run      <= 1'b1;
        from_plc <= plc_edge && !foot_edge;
        rt_cnt   <= 16'h0;
      end
      else if (run && tick)
        rt_cnt <= rt_cnt + 16'h1;
    end

    // led drive merges trigger and program control
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        led_on[c] <= 1'b0;
      else
        led_on[c] <= run || level_on || seq_led[c];
    end

    // fan only for units fitted with one
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        fan_on[c] <= 1'b0;
      else
        fan_on[c] <= has_fan[c] && led_temp[8*c +: 8] > fan_on_threshold;
    end
  end

  assign cur       = prog[line];
  assign cur_op    = lcs_op_t'(cur[`LCS_PW_OP_HI:`LCS_PW_OP_LO]);
  assign cur_arg   = cur[`LCS_PW_ARG_HI:`LCS_PW_ARG_LO];
  assign last_line = (line == `LCS_LAST_LINE);

  // sequencer state, line pointer and wait counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= LCS_IDLE;
      line     <= 7'h0;
      wait_cnt <= 16'h0;
    end
    else if (wr_stop)
    begin
      state <= LCS_IDLE;
      line  <= 7'h0;
    end
    else
    begin
      case (state)
        LCS_IDLE:
          if (wr_start)
          begin
            state    <= LCS_WAIT;
            line     <= 7'h0;
            wait_cnt <= 16'h0;
          end
        LCS_WAIT:
          if (wait_cnt >= cur[`LCS_PW_WAIT_HI:0])
            state <= LCS_EXEC;
          else if (tick)
            wait_cnt <= wait_cnt + 16'h1;
        LCS_EXEC:
        begin
          wait_cnt <= 16'h0;
          if (cur_op == LCS_OP_STOP)
          begin
            state <= LCS_IDLE;
            line  <= 7'h0;
          end
          else if (cur_op == LCS_OP_JUMP && cur_arg >= 8'h1 && cur_arg <= 8'(`LCS_LINES))
          begin
            state <= LCS_WAIT;
            line  <= 7'(cur_arg - 8'h1);
          end
          else if (last_line)
          begin
            state <= LCS_IDLE;
            line  <= 7'h0;
          end
          else
          begin
            state <= LCS_WAIT;
            line  <= line + 7'h1;
          end
        end
        default:
        begin
          state <= LCS_IDLE;
          line  <= 7'h0;
        end
      endcase
    end
  end

  // program-driven leds; channels without a unit are skipped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      seq_led <= 4'h0;
    else if (state == LCS_EXEC && cur_op == LCS_OP_LEON)
      seq_led <= seq_led | (cur_arg[3:0] & led_present);
    else if (state == LCS_EXEC && cur_op == LCS_OP_LEOF)
      seq_led <= seq_led & ~cur_arg[3:0];
  end

  // running flag for the outside world
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      seq_running <= 1'b0;
    else
      seq_running <= (state != LCS_IDLE);
  end

  // read data, valid only the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else if (reg_addr[7:4] == `LCS_BASE_POWER && reg_addr[1:0] == 2'h0)
      reg_rdata <= {24'h0, led_power[8*reg_addr[3:2] +: 8]};
    else if (reg_addr[7:4] == `LCS_BASE_TIME && reg_addr[1:0] == 2'h0)
      reg_rdata <= {16'h0, rad_time[reg_addr[3:2]]};
    else
    begin
      case (reg_addr)
        `LCS_ADDR_CTRL:   reg_rdata <= {29'h0, channel_grouping, trigger_input_mode};
        `LCS_ADDR_FAN:    reg_rdata <= {24'h0, fan_on_threshold};
        `LCS_ADDR_PADDR:  reg_rdata <= {25'h0, prog_addr};
        `LCS_ADDR_PDATA:  reg_rdata <= (prog_addr <= `LCS_LAST_LINE) ? {4'h0, prog[prog_addr]} : 32'h0;
        `LCS_ADDR_STATUS: reg_rdata <= {16'h0, fan_on, seq_led, state != LCS_IDLE, line};
        default:          reg_rdata <= 32'h0;
      endcase
    end
  end

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_start_line_one: assert property (state == LCS_IDLE && wr_start && !wr_stop |=> state == LCS_WAIT && line == 7'h0)
    else $error("start did not begin at line one");
  chk_stop_any_time: assert property (wr_stop |=> state == LCS_IDLE && line == 7'h0 ##1 !seq_running)
    else $error("stop request did not halt the sequencer");
  chk_last_line_halt: assert property (state == LCS_EXEC && last_line && cur_op != LCS_OP_JUMP && !wr_stop
    |=> state == LCS_IDLE)
    else $error("sequencer ran past the last line");
  chk_line_bound: assert property (line <= `LCS_LAST_LINE)
    else $error("line pointer beyond program store");
  chk_wait_before_exec: assert property (state == LCS_WAIT && wait_cnt < cur[`LCS_PW_WAIT_HI:0] |=> state != LCS_EXEC)
    else $error("instruction executed before its wait elapsed");
  chk_line_advance: assert property (state == LCS_EXEC && cur_op == LCS_OP_NOP && !last_line && !wr_stop
    |=> state == LCS_WAIT && line == $past(line) + 7'h1)
    else $error("line did not advance by one");
  chk_group_copy: assert property (reg_wr && reg_addr[7:4] == `LCS_BASE_POWER && channel_grouping == LCS_GRP_ALL
    |=> led_power[31:24] == $past(reg_wdata[7:0]))
    else $error("grouped power write not copied");
  chk_no_fan_unit: assert property (!has_fan[1] |=> !fan_on[1])
    else $error("fan driven on a unit without one");
  chk_fan_threshold: assert property (has_fan[0] && led_temp[7:0] > fan_on_threshold && $stable(fan_on_threshold)
    ##1 $stable(led_temp[7:0]) |-> fan_on[0])
    else $error("fan off above threshold");
  chk_foot_hold: assert property (trigger_input_mode == LCS_TRIG_STANDARD && rad_time[0] == 16'h0 && foot_switch
    |=> led_on[0])
    else $error("led not held by foot switch");
  chk_absent_skip: assert property (state == LCS_EXEC && cur_op == LCS_OP_LEON && !led_present[2] && !seq_led[2]
    |=> !seq_led[2])
    else $error("absent unit switched on by program");

  cov_full_run: cover property (state == LCS_EXEC && last_line ##1 state == LCS_IDLE);
  cov_jump: cover property (state == LCS_EXEC && cur_op == LCS_OP_JUMP ##1 state == LCS_WAIT);
  cov_abort: cover property (state == LCS_WAIT && wr_stop);
  cov_timed_shot: cover property (g_ch[0].run ##[1:20] !g_ch[0].run);
endmodule

//--- shared/lcs_defines.svh
// register offsets, field positions, reset values and timing counts of the curing sequencer
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH
`define LCS_ADDR_CTRL     8'h00
`define LCS_ADDR_FAN      8'h04
`define LCS_ADDR_PADDR    8'h08
`define LCS_ADDR_PDATA    8'h0c
`define LCS_ADDR_STATUS   8'h10
`define LCS_BASE_POWER    4'h2
`define LCS_BASE_TIME     4'h3
`define LCS_CTRL_MODE     0
`define LCS_CTRL_GRP_LO   1
`define LCS_CTRL_GRP_HI   2
`define LCS_CTRL_START    8
`define LCS_CTRL_STOP     9
`define LCS_FAN_RST       8'h23
`define LCS_POWER_RST     8'h64
`define LCS_LINES         99
`define LCS_LAST_LINE     7'h62
`define LCS_PW_WAIT_HI    15
`define LCS_PW_OP_LO      16
`define LCS_PW_OP_HI      19
`define LCS_PW_ARG_LO     20
`define LCS_PW_ARG_HI     27
`define LCS_TICK_MS       100
`define LCS_CLK_MHZ       100
`define LCS_TICK_CYCLES   (`LCS_TICK_MS * 1000 * `LCS_CLK_MHZ)
`endif

//--- shared/lcs_pkg.sv
// types shared by the curing sequencer
package lcs_pkg;
  typedef enum logic [2:0] {
    LCS_IDLE = 3'b001,
    LCS_WAIT = 3'b010,
    LCS_EXEC = 3'b100
  } lcs_seq_t;
  typedef enum logic [1:0] {
    LCS_GRP_SEPARATE = 2'h0,
    LCS_GRP_PAIRS    = 2'h1,
    LCS_GRP_ALL      = 2'h2
  } lcs_grp_t;
  typedef enum logic [3:0] {
    LCS_OP_NOP  = 4'h0,
    LCS_OP_LEON = 4'h1,
    LCS_OP_LEOF = 4'h2,
    LCS_OP_JUMP = 4'h3,
    LCS_OP_STOP = 4'h4
  } lcs_op_t;
  typedef enum logic {
    LCS_TRIG_STANDARD = 1'b0,
    LCS_TRIG_PULSE    = 1'b1
  } lcs_trig_t;
endpackage

//--- tb/lcs_far_end.sv
// far-side model: foot switch, controller input and led units
`timescale 1ns/1ps
module lcs_far_end (
  // clock
  input  wire logic        ref_clk,
  // triggers
  output logic             foot_switch,
  output logic             plc_in,
  // led units
  output logic [3:0]       led_present,
  output logic [3:0]       has_fan,
  output logic [31:0]      led_temp
);
  // idle levels from time zero: nothing pressed, no unit fitted
  initial
  begin
    foot_switch = 1'b0;
    plc_in      = 1'b0;
    led_present = 4'h0;
    has_fan     = 4'h0;
    led_temp    = 32'h0;
  end
  // unit set changes land just after an edge, like a real hot-plug
  task automatic set_units(input logic [3:0] pres, input logic [3:0] fan, input logic [31:0] temp);
    @(posedge ref_clk);
    led_present <= pres;
    has_fan     <= fan;
    led_temp    <= temp;
  endtask
  // trigger levels change one edge at a time
  task automatic trig(input logic foot, input logic plc);
    @(posedge ref_clk);
    foot_switch <= foot;
    plc_in      <= plc;
  endtask
endmodule

//--- tb/test_lcs_sequencer.sv
// self-checking bench for the curing sequencer
`timescale 1ns/1ps
`include "lcs_defines.svh"
module test_lcs_sequencer
  import lcs_pkg::*;
;
  // design signals
  logic        ref_clk;
  logic        reset_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        foot_switch;
  logic        plc_in;
  logic [3:0]  led_present;
  logic [3:0]  has_fan;
  logic [31:0] led_temp;
  logic [3:0]  led_on;
  logic [31:0] led_power;
  logic [3:0]  fan_on;
  logic        seq_running;
  // bench state
  int          n_fail;
  int          comparisons;
  int          src;
  logic [7:0]  pw [4];
  logic [31:0] d;

  // short tick so program waits stay a few cycles long
  lcs_sequencer #(.TICK_CYCLES(4)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .foot_switch(foot_switch),
    .plc_in(plc_in), .led_present(led_present), .has_fan(has_fan), .led_temp(led_temp),
    .led_on(led_on), .led_power(led_power), .fan_on(fan_on), .seq_running(seq_running));

  lcs_far_end far (
    .ref_clk(ref_clk), .foot_switch(foot_switch), .plc_in(plc_in),
    .led_present(led_present), .has_fan(has_fan), .led_temp(led_temp));

  // 100 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // four-state compare so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // sample a little after the edge so design updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  function automatic logic [31:0] lw(input logic [15:0] w, input lcs_op_t op, input logic [7:0] arg);
    return {4'h0, arg, op, w};
  endfunction

  // first program: timed led-on, forward jump over line 3, last line sets led 4
  function automatic logic [31:0] prog(input int i);
    case (i)
      0:       return lw(16'h1, LCS_OP_LEON, 8'h07);
      1:       return lw(16'h0, LCS_OP_JUMP, 8'h04);
      2:       return lw(16'h0, LCS_OP_LEON, 8'h04);
      3:       return lw(16'h0, LCS_OP_LEOF, 8'h01);
      98:      return lw(16'h0, LCS_OP_LEON, 8'h08);
      default: return lw(16'h0, LCS_OP_NOP, 8'h00);
    endcase
  endfunction

  // bounded wait for the sequencer to go idle
  task automatic wait_idle;
    tick(3);
    for (int i = 0; i < 2000 && seq_running !== 1'b0; i++)
      tick(1);
    // a sequencer that never halts counts as a mismatch
    check(32'(seq_running), 32'h0);
  endtask

  // hang guard, well above the expected run of a few hundred cycles
  initial
  begin
    #300000;
    n_fail++;
    end_of_test;
  end

  initial
  begin
    reset_n   = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values and an unmapped place
    rdc(`LCS_ADDR_CTRL, 32'h0);
    rdc(`LCS_ADDR_FAN, 32'h23);
    rdc(8'h40, 32'h0);
    check(led_power, 32'h64646464);
    wr(`LCS_ADDR_CTRL, 32'h1);
    rdc(`LCS_ADDR_CTRL, 32'h1);
    // each grouping: one write must reach exactly its group
    for (int c = 0; c < 4; c++)
      pw[c] = 8'h64;
    for (int g = 0; g < 3; g++)
    begin
      src = (g == 0) ? 3 : (g == 1) ? 0 : 2;
      wr(`LCS_ADDR_CTRL, 32'(g) << 1);
      wr(8'(8'h20 + 4 * src), 32'(8'h10 + g));
      wr(8'(8'h30 + 4 * src), 32'(16 + g));
      for (int c = 0; c < 4; c++)
        if (g == 2 || c == src || (g == 1 && c / 2 == src / 2))
          pw[c] = 8'(8'h10 + g);
      tick(1);
      check(led_power, {pw[3], pw[2], pw[1], pw[0]});
      rdc(8'(8'h30 + 4 * (src ^ 1)), (g == 0) ? 32'h0 : 32'(16 + g));
    end
    // triggers in standard mode, all channels one group
    far.set_units(4'hf, 4'b1101, {8'h50, 8'h23, 8'h24, 8'h24});
    wr(`LCS_ADDR_CTRL, 32'h4);
    wr(8'h30, 32'h0);
    far.trig(1'b1, 1'b0);
    tick(3);
    check(32'(led_on), 32'hf);
    far.trig(1'b0, 1'b0);
    tick(3);
    check(32'(led_on), 32'h0);
    // timed shot outlives a short press, then expires
    wr(8'h30, 32'h2);
    far.trig(1'b1, 1'b0);
    far.trig(1'b0, 1'b0);
    tick(2);
    check(32'(led_on), 32'hf);
    tick(16);
    check(32'(led_on), 32'h0);
    // controller held high longer than the set time
    far.trig(1'b0, 1'b1);
    tick(3);
    check(32'(led_on), 32'hf);
    tick(16);
    check(32'(led_on), 32'h0);
    far.trig(1'b0, 1'b0);
    // pulse mode: one press starts, the next press ends long before expiry
    wr(`LCS_ADDR_CTRL, 32'h5);
    wr(8'h30, 32'h40);
    far.trig(1'b1, 1'b0);
    far.trig(1'b0, 1'b0);
    tick(2);
    check(32'(led_on), 32'hf);
    far.trig(1'b1, 1'b0);
    tick(2);
    check(32'(led_on), 32'h0);
    far.trig(1'b0, 1'b0);
    // fan: strictly above threshold, fitted units only
    check(32'(fan_on), 32'h9);
    wr(`LCS_ADDR_FAN, 32'h24);
    tick(3);
    check(32'(fan_on), 32'h8);
    // program load, channel 3 absent
    far.set_units(4'b1011, 4'b1101, {8'h50, 8'h23, 8'h24, 8'h24});
    wr(`LCS_ADDR_CTRL, 32'h0);
    wr(`LCS_ADDR_PADDR, 32'h0);
    for (int i = 0; i < 99; i++)
      wr(`LCS_ADDR_PDATA, prog(i));
    wr(`LCS_ADDR_PADDR, 32'h1);
    rdc(`LCS_ADDR_PDATA, lw(16'h0, LCS_OP_JUMP, 8'h04));
    wr(`LCS_ADDR_CTRL, 32'h100);
    tick(2);
    check(32'(led_on), 32'h0);
    wait_idle;
    rd(`LCS_ADDR_STATUS, d);
    check(d & 32'hf80, 32'ha00);
    check(32'(led_on), 32'ha);
    // long wait on line 5, then a stop request
    wr(`LCS_ADDR_PADDR, 32'h4);
    wr(`LCS_ADDR_PDATA, lw(16'hffff, LCS_OP_NOP, 8'h00));
    wr(`LCS_ADDR_CTRL, 32'h100);
    tick(30);
    check(32'(seq_running), 32'h1);
    wr(`LCS_ADDR_CTRL, 32'h200);
    tick(3);
    check(32'(seq_running), 32'h0);
    // restart must begin at line 1, not where it stopped
    wr(`LCS_ADDR_PADDR, 32'h0);
    wr(`LCS_ADDR_PDATA, lw(16'h0, LCS_OP_LEOF, 8'h0f));
    wr(`LCS_ADDR_PADDR, 32'h4);
    wr(`LCS_ADDR_PDATA, lw(16'h0, LCS_OP_STOP, 8'h00));
    wr(`LCS_ADDR_CTRL, 32'h100);
    wait_idle;
    rd(`LCS_ADDR_STATUS, d);
    check(d & 32'hf80, 32'h0);
    check(32'(led_on), 32'h0);
    end_of_test;
  end
endmodule
